// ===== src/ptm_map.vh
`ifndef PTM_MAP_VH
`define PTM_MAP_VH

// register offsets, byte addresses on the plain register port
`define PTM_ADDR_W 8
`define PTM_OFS_CTRL 8'h00
`define PTM_OFS_SELECT 8'h04
`define PTM_OFS_INDEX 8'h08
`define PTM_OFS_VALUE 8'h0C
`define PTM_OFS_GAMMA 8'h10
`define PTM_OFS_STATUS 8'h14

// control register fields
`define PTM_CTRL_TABLE_EN 0
`define PTM_CTRL_FMT8 1
`define PTM_CTRL_PRESET 2
`define PTM_CTRL_RST 3'h0

// status register fields
`define PTM_STAT_PRESET_GAMMA 0
`define PTM_STAT_SELECT_OK 1

// table selection codes; the luminance table is the only one
`define PTM_SEL_W 4
`define PTM_SEL_LUMINANCE 4'h0

// table geometry
`define PTM_PIX_W 12
`define PTM_IDX_W 12
`define PTM_KNOT_SHIFT 3
`define PTM_LAST_KNOT 12'hFF8

// gamma exponent, unsigned 2.16 fixed point
`define PTM_GAMMA_W 18
`define PTM_GAMMA_ONE 18'h10000
`define PTM_GAMMA_PRESET 18'h06666

// normalisation maxima and their log2 in 4.12 fixed point
`define PTM_MAX8 12'h0FF
`define PTM_MAX12 12'hFFF
`define PTM_LOG_W8 16'h8000
`define PTM_LOG_W12 16'hC000
`define PTM_FRAC_W 12

// bend factor of the log and exp fractions, 11/32
`define PTM_BEND_MUL 4'hB
`define PTM_BEND_SHIFT 5

`endif

// ===== src/ptm_table_mem.v
`timescale 1ns/100ps
// one write port, two read ports with registered read data
module ptm_table_mem #(
   parameter AW = 12,
   parameter DW = 12
) (
   input wire clk,
   input wire wrEn,
   input wire [AW-1:0] wrAddr,
   input wire [DW-1:0] wrData,
   input wire [AW-1:0] rdAddrA,
   input wire [AW-1:0] rdAddrB,
   output reg [DW-1:0] rdDataA,
   output reg [DW-1:0] rdDataB
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
   end
endmodule // ptm_table_mem

// ===== src/ptm_tone_map.v
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "ptm_map.vh"
// How it works
// - table on and 8-bit format: map through table, then keep upper 8 bits
// - select field picks the table; only the luminance table is accepted
// - index field picks the entry to change, counting from 0 upward
// - writing the value field stores it at the entry the index names
// - table-enable bit switches the lookup in or out of the path
// - gamma works on red, green and blue component values only; the code applies it to every pixel alike
// - output is (input / max) to the power gamma, times max
// - max is 255 for 8-bit output and 4095 for 12-bit output
// - exponent field accepts 0 up to 3.99998 inclusive
// - exponent 1 passes values unchanged and is the reset value
// - zero and the format maximum always pass gamma unchanged
// - gamma acts on already binned pixel data, after binning
// - light source preset forces an exponent of about 0.4
// - table holds 4096 entries; only multiples of 8 are used
// - inputs between used entries get straight-line interpolation
// - inputs above 4088 get the entry at 4088 as is
module ptm_tone_map (
   input wire core_clk,
   input wire sys_rst,
   input wire [`PTM_ADDR_W-1:0] regAddr,
   input wire [31:0] regWrData,
   input wire regWrStrobe,
   input wire regRdStrobe,
   output reg [31:0] regRdData,
   input wire [`PTM_PIX_W-1:0] pixIn,
   input wire pixInValid,
   output reg [`PTM_PIX_W-1:0] pixOut,
   output reg pixOutValid
);
   // configuration
   reg tableEnable;
   reg fmt8;
   reg presetActive;
   reg [`PTM_SEL_W-1:0] tableSelect;
   reg [`PTM_IDX_W-1:0] entryIndex;
   reg [`PTM_PIX_W-1:0] entryValueShadow;
   reg [`PTM_GAMMA_W-1:0] gammaSet;
   wire [`PTM_GAMMA_W-1:0] gammaEff;
   wire selectOk;
   wire tableWrite;

   // stage 1: table addresses issued
   reg s1Valid;
   reg [`PTM_PIX_W-1:0] s1Pix;
   reg [`PTM_KNOT_SHIFT-1:0] s1Frac;
   reg s1Over;
   wire [`PTM_IDX_W-1:0] knotLo;
   wire [`PTM_IDX_W-1:0] knotHi;
   wire [`PTM_PIX_W-1:0] tblLo;
   wire [`PTM_PIX_W-1:0] tblHi;

   // stage 2: looked-up and width-reduced value
   reg s2Valid;
   reg [`PTM_PIX_W-1:0] s2Val;
   reg [`PTM_PIX_W-1:0] next_s2Val;
   reg [`PTM_PIX_W-1:0] mapped;
   reg signed [13:0] slopeDiff;
   reg signed [17:0] slopeStep;
   // the width and the exponent travel with each pixel, so a register write
   // in mid-stream changes whole pixels and never half of one
   reg s2Fmt8;

   // stage 3: log domain distance below the maximum
   reg s3Valid;
   reg [`PTM_PIX_W-1:0] s3Val;
   reg [15:0] s3Dist;
   reg [15:0] s3LogW;
   reg [`PTM_PIX_W-1:0] s3Max;
   reg s3Bypass;
   reg [`PTM_GAMMA_W-1:0] s3Gamma;

   // stage 4: distance scaled by the exponent
   reg s4Valid;
   reg [`PTM_PIX_W-1:0] s4Val;
   reg [17:0] s4Scaled;
   reg [15:0] s4LogW;
   reg [`PTM_PIX_W-1:0] s4Max;
   reg s4Bypass;
   wire [33:0] scaledProd;

   // stage 5 combinational terms
   wire [15:0] expArg;
   wire [24:0] expVal;
   wire [12:0] expInt;
   wire [12:0] expRound;
   wire [11:0] expMant;
   reg [`PTM_PIX_W-1:0] next_pixOut;

   // c*f*(1-f) with c = 11/32 lifts a straight-line log2 fraction, or lowers a
   // straight-line exp2 fraction, to within about half a percent of the curve
   function [11:0] ptmBend;
      input [11:0] f;
      reg [11:0] rest;
      reg [23:0] prod;
      reg [15:0] scaled;
      begin
         rest = ~f;
         prod = f * rest;
         scaled = (prod[23:12] * `PTM_BEND_MUL) >> `PTM_BEND_SHIFT;
         ptmBend = scaled[11:0];
      end
   endfunction

   // leading-one position and mantissa, 4.12 fixed point log2
   // zero gives zero; the bypass path catches black before it matters
   function [15:0] ptmLog2;
      input [11:0] x;
      integer i;
      reg [3:0] msb;
      reg [11:0] norm;
      reg [11:0] frac;
      begin
         msb = 4'h0;
         for (i = 0; i < 12; i = i + 1) begin
            if (x[i]) begin
               msb = i[3:0];
            end
         end
         norm = x << (4'hB - msb);
         frac = {norm[10:0], 1'b0};
         ptmLog2 = {msb, frac + ptmBend(frac)};
      end
   endfunction

   // format maximum for the selected output width
   function [11:0] ptmFmtMax;
      input is8;
      begin
         ptmFmtMax = is8 ? `PTM_MAX8 : `PTM_MAX12;
      end
   endfunction

   assign selectOk = (tableSelect == `PTM_SEL_LUMINANCE);
   // the preset overrides a stored exponent without destroying it
   assign gammaEff = presetActive ? `PTM_GAMMA_PRESET : gammaSet;
   assign tableWrite = regWrStrobe && (regAddr == `PTM_OFS_VALUE) && selectOk;

   // register writes
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tableEnable <= 1'b0;
         fmt8 <= 1'b0;
         presetActive <= 1'b0;
         tableSelect <= `PTM_SEL_LUMINANCE;
         entryIndex <= {`PTM_IDX_W{1'b0}};
         entryValueShadow <= {`PTM_PIX_W{1'b0}};
         gammaSet <= `PTM_GAMMA_ONE;
      end else if (regWrStrobe) begin
         if (regAddr == `PTM_OFS_CTRL) begin
            tableEnable <= regWrData[`PTM_CTRL_TABLE_EN];
            fmt8 <= regWrData[`PTM_CTRL_FMT8];
            presetActive <= regWrData[`PTM_CTRL_PRESET];
         end else if (regAddr == `PTM_OFS_SELECT) begin
            // any code but the luminance table is refused
            if (regWrData[`PTM_SEL_W-1:0] == `PTM_SEL_LUMINANCE) begin
               tableSelect <= regWrData[`PTM_SEL_W-1:0];
            end
         end else if (regAddr == `PTM_OFS_INDEX) begin
            entryIndex <= regWrData[`PTM_IDX_W-1:0];
         end else if (regAddr == `PTM_OFS_VALUE) begin
            entryValueShadow <= regWrData[`PTM_PIX_W-1:0];
         end else if (regAddr == `PTM_OFS_GAMMA) begin
            // full 2.16 range, 0 to 3.99998, is legal
            gammaSet <= regWrData[`PTM_GAMMA_W-1:0];
         end
      end
   end

   // register reads, data valid the cycle after the strobe
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData <= 32'h00000000;
      end else if (regRdStrobe) begin
         if (regAddr == `PTM_OFS_CTRL) begin
            regRdData <= {29'h0, presetActive, fmt8, tableEnable};
         end else if (regAddr == `PTM_OFS_SELECT) begin
            regRdData <= {28'h0, tableSelect};
         end else if (regAddr == `PTM_OFS_INDEX) begin
            regRdData <= {20'h0, entryIndex};
         end else if (regAddr == `PTM_OFS_VALUE) begin
            regRdData <= {20'h0, entryValueShadow};
         end else if (regAddr == `PTM_OFS_GAMMA) begin
            regRdData <= {14'h0, gammaEff};
         end else if (regAddr == `PTM_OFS_STATUS) begin
            regRdData <= {30'h0, selectOk, presetActive};
         end else begin
            regRdData <= 32'h00000000;
         end
      end else begin
         regRdData <= 32'h00000000;
      end
   end

   // all 4096 entries are stored; only the knots are ever read
   ptm_table_mem #(
      .AW(`PTM_IDX_W),
      .DW(`PTM_PIX_W)
   ) tableMem (
      .clk(core_clk),
      .wrEn(tableWrite),
      .wrAddr(entryIndex),
      .wrData(regWrData[`PTM_PIX_W-1:0]),
      .rdAddrA(knotLo),
      .rdAddrB(knotHi),
      .rdDataA(tblLo),
      .rdDataB(tblHi)
   );

   // knot below the pixel and the knot above it; past 4088 both sit on 4088
   assign knotLo = {pixIn[`PTM_PIX_W-1:`PTM_KNOT_SHIFT], {`PTM_KNOT_SHIFT{1'b0}}};
   assign knotHi = (knotLo == `PTM_LAST_KNOT) ? `PTM_LAST_KNOT :
      knotLo + {{(`PTM_IDX_W-`PTM_KNOT_SHIFT-1){1'b0}}, 1'b1, {`PTM_KNOT_SHIFT{1'b0}}};

   // stage 1
   // the table read is registered, so the pixel waits one stage to meet it
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1Valid <= 1'b0;
         s1Pix <= {`PTM_PIX_W{1'b0}};
         s1Frac <= {`PTM_KNOT_SHIFT{1'b0}};
         s1Over <= 1'b0;
      end else begin
         s1Valid <= pixInValid;
         s1Pix <= pixIn;
         s1Frac <= pixIn[`PTM_KNOT_SHIFT-1:0];
         s1Over <= (pixIn > `PTM_LAST_KNOT);
      end
   end

   // stage 2: interpolate, then reduce width
   always @* begin
      slopeDiff = $signed({2'b00, tblHi}) - $signed({2'b00, tblLo});
      slopeStep = slopeDiff * $signed({1'b0, s1Frac});
      if (!tableEnable) begin
         mapped = s1Pix;
      end else if (s1Over) begin
         mapped = tblLo;
      end else begin
         // floor division by the knot spacing; exact at every knot
         mapped = tblLo + slopeStep[`PTM_KNOT_SHIFT+11:`PTM_KNOT_SHIFT];
      end
      if (fmt8) begin
         next_s2Val = {4'h0, mapped[11:4]};
      end else begin
         next_s2Val = mapped;
      end
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s2Valid <= 1'b0;
         s2Val <= {`PTM_PIX_W{1'b0}};
         s2Fmt8 <= 1'b0;
      end else begin
         s2Valid <= s1Valid;
         s2Val <= next_s2Val;
         s2Fmt8 <= fmt8;
      end
   end

   // stage 3: upstream binning has already merged the components, so the
   // per-component gamma below sees binned data
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s3Valid <= 1'b0;
         s3Val <= {`PTM_PIX_W{1'b0}};
         s3Dist <= 16'h0000;
         s3LogW <= `PTM_LOG_W12;
         s3Max <= `PTM_MAX12;
         s3Bypass <= 1'b1;
         s3Gamma <= `PTM_GAMMA_ONE;
      end else begin
         s3Valid <= s2Valid;
         s3Val <= s2Val;
         s3LogW <= s2Fmt8 ? `PTM_LOG_W8 : `PTM_LOG_W12;
         s3Max <= ptmFmtMax(s2Fmt8);
         s3Dist <= (s2Fmt8 ? `PTM_LOG_W8 : `PTM_LOG_W12) - ptmLog2(s2Val);
         s3Gamma <= gammaEff;
         // black, white and unity exponent take the exact path
         s3Bypass <= (s2Val == {`PTM_PIX_W{1'b0}}) || (s2Val == ptmFmtMax(s2Fmt8)) ||
            (gammaEff == `PTM_GAMMA_ONE);
      end
   end

   // 4.12 distance times 2.16 exponent; the top 18 bits keep the 4.12 scale
   assign scaledProd = s3Dist * s3Gamma;

   // stage 4
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s4Valid <= 1'b0;
         s4Val <= {`PTM_PIX_W{1'b0}};
         s4Scaled <= 18'h00000;
         s4LogW <= `PTM_LOG_W12;
         s4Max <= `PTM_MAX12;
         s4Bypass <= 1'b1;
      end else begin
         s4Valid <= s3Valid;
         s4Val <= s3Val;
         s4Scaled <= scaledProd[33:16];
         s4LogW <= s3LogW;
         s4Max <= s3Max;
         s4Bypass <= s3Bypass;
      end
   end

   // stage 5: back out of the log domain; the bend keeps the error to about
   // one percent, and the half bit below the integer rounds to nearest
   assign expArg = s4LogW - s4Scaled[15:0];
   assign expMant = expArg[`PTM_FRAC_W-1:0] - ptmBend(expArg[`PTM_FRAC_W-1:0]);
   assign expVal = {12'h000, 1'b1, expMant} << expArg[15:12];
   assign expInt = expVal[24:12];
   assign expRound = expInt + {12'h000, expVal[11]};

   always @* begin
      if (s4Bypass) begin
         next_pixOut = s4Val;
      end else if (s4Scaled >= {2'b00, s4LogW}) begin
         next_pixOut = {`PTM_PIX_W{1'b0}};
      end else if (expRound > {1'b0, s4Max}) begin
         // results a little past the maximum, or exponent 0, clamp to it
         next_pixOut = s4Max;
      end else begin
         next_pixOut = expRound[11:0];
      end
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pixOutValid <= 1'b0;
         pixOut <= {`PTM_PIX_W{1'b0}};
      end else begin
         pixOutValid <= s4Valid;
         pixOut <= next_pixOut;
      end
   end
endmodule // ptm_tone_map

// ===== sim/ptm_adc_src.sv
`timescale 1ns/100ps
module ptm_adc_src (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic go,
   input wire logic [11:0] val,
   output logic [11:0] pix,
   output logic pixValid
);
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pix <= 12'h000;
         pixValid <= 1'b0;
      end else begin
         pixValid <= go;
         // between pixels the line toggles so a stale value cannot pass
         pix <= go ? val : ~pix;
      end
   end
endmodule // ptm_adc_src

// ===== sim/ptm_tone_map_assertions.sv
`timescale 1ns/100ps
`include "ptm_map.vh"
module ptm_tone_map_chk (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   input wire logic [31:0] regRdData,
   input wire logic [11:0] pixIn,
   input wire logic pixInValid,
   input wire logic [11:0] pixOut,
   input wire logic pixOutValid
);
   logic [2:0] ctrl;
   logic [17:0] gam;
   logic [2:0] age;
   // config must sit still for the whole pipe before outputs are judged
   wire quiet = age == 3'h7;
   wire plain = quiet && !ctrl[0] && !ctrl[2] && gam == `PTM_GAMMA_ONE;
   wire cfgWr = regWrStrobe && (regAddr == `PTM_OFS_CTRL || regAddr == `PTM_OFS_GAMMA);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= `PTM_CTRL_RST;
         gam <= `PTM_GAMMA_ONE;
         age <= 3'h0;
      end else begin
         if (regWrStrobe && regAddr == `PTM_OFS_CTRL) ctrl <= regWrData[2:0];
         if (regWrStrobe && regAddr == `PTM_OFS_GAMMA) gam <= regWrData[17:0];
         age <= cfgWr ? 3'h0 : (quiet ? age : age + 3'h1);
      end
   end
   valid_delay_a: assert property (pixOutValid == $past(pixInValid, 5))
      else $error("output valid not five cycles after input");
   rd_idle_a: assert property (!$past(regRdStrobe) |-> regRdData == 32'h0)
      else $error("read data outside answer cycle");
   pass_wide_a: assert property (pixOutValid && plain && !ctrl[1] |-> pixOut == $past(pixIn, 5))
      else $error("12-bit pixel altered");
   pass_narrow_a: assert property (pixOutValid && plain && ctrl[1] |-> pixOut == {4'h0, $past(pixIn[11:4], 5)})
      else $error("8-bit pixel not upper bits");
   black_kept_a: assert property (pixOutValid && quiet && !ctrl[0] && $past(pixIn, 5) == 12'h000 |-> pixOut == 12'h000)
      else $error("black changed");
   white_kept_a: assert property (pixOutValid && quiet && !ctrl[0] && (ctrl[1] ? $past(pixIn[11:4], 5) == 8'hFF
      : $past(pixIn, 5) == 12'hFFF) |-> pixOut == (ctrl[1] ? `PTM_MAX8 : `PTM_MAX12))
      else $error("white changed");
   narrow_width_a: assert property (pixOutValid && quiet && ctrl[1] |-> pixOut[11:8] == 4'h0)
      else $error("8-bit output too wide");
   gamma_read_a: assert property (regRdStrobe && regAddr == `PTM_OFS_GAMMA
      |=> regRdData == {14'h0000, ctrl[2] ? `PTM_GAMMA_PRESET : gam})
      else $error("exponent readback wrong");
   select_fixed_a: assert property (regRdStrobe && regAddr == `PTM_OFS_SELECT |=> regRdData == 32'h0)
      else $error("illegal table selected");
   cover property (pixOutValid && quiet && ctrl[1:0] == 2'h3);
   cover property (regRdStrobe && regAddr == `PTM_OFS_GAMMA && ctrl[2]);
   cover property (pixOutValid && plain);
endmodule // ptm_tone_map_chk
bind ptm_tone_map ptm_tone_map_chk chk (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
   .pixIn(pixIn), .pixInValid(pixInValid), .pixOut(pixOut), .pixOutValid(pixOutValid));

// ===== sim/tb_pixel_tone_mapping.sv
`timescale 1ns/100ps
`include "ptm_map.vh"
module tb_pixel_tone_mapping;
   logic core_clk, sys_rst, regWrStrobe, regRdStrobe, pixInValid, pixOutValid, go;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData;
   logic [11:0] pixIn, pixOut, val;
   logic [15:0] lf;
   int bad_count, check_count, cycles, e, tl;
   int tbl [0:511];
   int expQ [$];
   int tolQ [$];
   int corner [0:5] = '{0, 8, 4087, 4088, 4095, 2052};
   ptm_tone_map dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData), .pixIn(pixIn),
      .pixInValid(pixInValid), .pixOut(pixOut), .pixOutValid(pixOutValid));
   ptm_adc_src src (.core_clk(core_clk), .sys_rst(sys_rst), .go(go), .val(val), .pix(pixIn),
      .pixValid(pixInValid));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   function logic [15:0] nxt(input logic [15:0] s);
      nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task test_done;
      if (bad_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge core_clk);
      regWrStrobe <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      @(posedge core_clk);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge core_clk);
      regRdStrobe <= 1'b0;
      #1;
      check(regRdData, x);
   endtask
   // floor division keeps falling segments exact at the knots
   function int lut(input int x);
      int k, p;
      k = x >> 3;
      p = (tbl[k < 511 ? k + 1 : 511] - tbl[k]) * (x & 7);
      lut = x >= 4088 ? tbl[511] : tbl[k] + (p >= 0 ? p / 8 : -((7 - p) / 8));
   endfunction
   task run(input logic [2:0] c, input logic [17:0] g);
      logic [17:0] gg;
      real m;
      int x, w;
      gg = c[2] ? `PTM_GAMMA_PRESET : g;
      m = c[1] ? 255.0 : 4095.0;
      wr(`PTM_OFS_CTRL, {29'h0, c});
      wr(`PTM_OFS_GAMMA, {14'h0, g});
      rd(`PTM_OFS_GAMMA, {14'h0, gg});
      for (int i = 0; i < 200; i++) begin
         lf = nxt(lf);
         x = i < 6 ? corner[i] : lf[11:0];
         w = c[0] ? lut(x) : x;
         w = c[1] ? w >> 4 : w;
         @(posedge core_clk);
         go <= 1'b1;
         val <= x[11:0];
         expQ.push_back(gg == `PTM_GAMMA_ONE || w == 0 || w == int'(m) ? w : int'($pow(w / m, gg / 65536.0) * m));
         tolQ.push_back(gg == `PTM_GAMMA_ONE || w == 0 || w == int'(m) ? 0 : int'(m * 0.06) + 1);
      end
      @(posedge core_clk);
      go <= 1'b0;
      repeat (8) @(posedge core_clk);
      check(expQ.size(), 0);
   endtask
   always @(posedge core_clk) begin
      if (pixOutValid === 1'b1) begin
         e = expQ.size() > 0 ? expQ.pop_front() : -9999;
         tl = tolQ.size() > 0 ? tolQ.pop_front() : 0;
         check({31'h0, (pixOut > e ? pixOut - e : e - pixOut) <= tl}, 32'h1);
      end
   end
   // the table load dominates the run, about 6080 cycles in all
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         test_done;
      end
   end
   initial begin
      sys_rst = 1'b1;
      regAddr = 8'h00;
      regWrData = 32'h0;
      regWrStrobe = 1'b0;
      regRdStrobe = 1'b0;
      go = 1'b0;
      val = 12'h000;
      lf = 16'h6D95;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(`PTM_OFS_GAMMA, 32'h10000);
      rd(`PTM_OFS_CTRL, 32'h0);
      wr(`PTM_OFS_SELECT, 32'h5);
      rd(`PTM_OFS_SELECT, 32'h0);
      rd(`PTM_OFS_STATUS, 32'h2);
      rd(8'h40, 32'h0);
      wr(`PTM_OFS_INDEX, 32'h5);
      rd(`PTM_OFS_INDEX, 32'h5);
      wr(`PTM_OFS_VALUE, 32'h123);
      rd(`PTM_OFS_VALUE, 32'h123);
      for (int k = 0; k < 512; k++) begin
         lf = nxt(lf);
         tbl[k] = lf[11:0];
         wr(`PTM_OFS_INDEX, k * 8);
         wr(`PTM_OFS_VALUE, {20'h0, lf[11:0]});
         wr(`PTM_OFS_INDEX, k * 8 + 1);
         wr(`PTM_OFS_VALUE, {20'h0, ~lf[11:0]});
      end
      run(3'h1, `PTM_GAMMA_ONE);
      run(3'h3, `PTM_GAMMA_ONE);
      run(3'h0, `PTM_GAMMA_ONE);
      run(3'h2, `PTM_GAMMA_ONE);
      run(3'h0, 18'h20000);
      run(3'h2, 18'h08000);
      run(3'h1, 18'h3FFFF);
      run(3'h4, 18'h20000);
      rd(`PTM_OFS_STATUS, 32'h3);
      // a second reset in mid-run must bring back the unity exponent and defaults
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(`PTM_OFS_GAMMA, 32'h10000);
      rd(`PTM_OFS_CTRL, 32'h0);
      rd(`PTM_OFS_STATUS, 32'h2);
      run(3'h0, 18'h0C000);
      test_done;
   end
endmodule // tb_pixel_tone_mapping
